// ### hdl/psq_pkg.sv
// constants, types and helpers shared by the power state sequencer
package psq_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    // slot spacing choices, selected by a two-bit timing field
    localparam int SLOT_T0_US = 1000;
    localparam int SLOT_T1_US = 2000;
    localparam int SLOT_T2_US = 4000;
    localparam int SLOT_T3_US = 8000;
    localparam int unsigned SLOT_CYC0 = (SLOT_T0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOT_CYC1 = (SLOT_T1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOT_CYC2 = (SLOT_T2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLOT_CYC3 = (SLOT_T3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // nonvolatile write time
    localparam int BURN_TIME_MS = 100;
    localparam int unsigned BURN_CYC = BURN_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================================
    // sizes
    localparam int NRAIL = 8;
    localparam int NBUCK = 4;
    localparam int NCFG = 12;
    localparam int NSYNC = 4 + 2 * NBUCK;

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_RAIL_SLOT0 = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_GRP_MASK = 8'h09;
    localparam logic [7:0] REG_DIS_MASK = 8'h0A;
    localparam logic [7:0] REG_RST_DLY = 8'h0B;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MODE = 8'h0D;
    localparam logic [7:0] REG_PASSWORD = 8'h26;

    // ==========================================================
    // field positions
    localparam int CTRL_UP_SEL_LSB = 0;
    localparam int CTRL_DN_SEL_LSB = 2;
    localparam int CTRL_KEY_EDGE_BIT = 4;
    localparam int CTRL_GRP_FUNC_BIT = 5;
    localparam int CTRL_GRP_POL_BIT = 6;
    localparam int MODE_CFG_BIT = 0;
    localparam int MODE_BURN_BIT = 1;
    localparam int STAT_CSUM_BIT = 4;
    localparam int STAT_THERM_BIT = 5;

    // ==========================================================
    // types and reset values
    typedef logic [NCFG-1:0][7:0] psq_cfg_t;

    // rail n: up slot n in low nibble, down slot 7-n in high nibble; discharge on
    localparam psq_cfg_t CFG_DEFAULT = {8'h00, 8'hFF, 8'h00, 8'h00,
                                        8'h07, 8'h16, 8'h25, 8'h34,
                                        8'h43, 8'h52, 8'h61, 8'h70};

    typedef enum logic [3:0] {
        ST_NO_SUPPLY,
        ST_LOAD,
        ST_SHUTDOWN,
        ST_UP_SEQ,
        ST_RST_WAIT,
        ST_ON,
        ST_DN_SEQ,
        ST_NVM_CFG,
        ST_NVM_BURN
    } psq_state_t;

    // ==========================================================
    // checksum: inverted byte sum, so an erased all-zero store never matches
    function automatic logic [7:0] psq_csum(input psq_cfg_t c);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < NCFG; i++) begin
            s = s + c[i];
        end
        return ~s;
    endfunction

endpackage

// ### hdl/psq_slot_timer.sv
// slot timer: counts slot periods and reports the running slot index
`timescale 1ns/10ps
`default_nettype none
module psq_slot_timer #(
    parameter int unsigned CYC0 = psq_pkg::SLOT_CYC0,
    parameter int unsigned CYC1 = psq_pkg::SLOT_CYC1,
    parameter int unsigned CYC2 = psq_pkg::SLOT_CYC2,
    parameter int unsigned CYC3 = psq_pkg::SLOT_CYC3
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic [3:0] slot_o,
    output logic tick_o
);
    import psq_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic [3:0] slot;
    } psq_tmr_t;

    psq_tmr_t r_ff;
    psq_tmr_t nxt_r;
    logic [31:0] lim;

    // ==========================================================
    // slot length select and count
    always_comb begin
        case (sel_i)
            2'h0: lim = CYC0;
            2'h1: lim = CYC1;
            2'h2: lim = CYC2;
            default: lim = CYC3;
        endcase
        // tick ignores clr so that the caller may derive clr from it
        tick_o = run_i && (r_ff.cnt == lim - 32'h1);
        nxt_r = r_ff;
        if (clr_i) begin
            nxt_r = '0;
        end else if (run_i) begin
            if (tick_o) begin
                nxt_r.cnt = 32'h0;
                // saturate at the last slot; callers stop before wrapping matters
                if (r_ff.slot != 4'hF) begin
                    nxt_r.slot = r_ff.slot + 4'h1;
                end
            end else begin
                nxt_r.cnt = r_ff.cnt + 32'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_ff <= '0;
        end else if (ce_i) begin
            r_ff <= nxt_r;
        end
    end

    assign slot_o = r_ff.slot;

endmodule
`default_nettype wire

// ### hdl/psq_power_state_sequencer.sv
// power state machine with slot sequencing, reset output and nonvolatile config
`timescale 1ns/10ps
`default_nettype none
module psq_power_state_sequencer #(
    parameter int unsigned SLOT_CYC0 = psq_pkg::SLOT_CYC0,
    parameter int unsigned SLOT_CYC1 = psq_pkg::SLOT_CYC1,
    parameter int unsigned SLOT_CYC2 = psq_pkg::SLOT_CYC2,
    parameter int unsigned SLOT_CYC3 = psq_pkg::SLOT_CYC3,
    parameter int unsigned BURN_CYC = psq_pkg::BURN_CYC,
    parameter logic [7:0] PROG_PASSWORD = 8'h5A // arbitrary value
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic bias_supply_ok_i,
    input wire logic thermal_sd_i,
    input wire logic power_key_pin_i,
    input wire logic rail_group_enable_pin_i,
    input wire logic [psq_pkg::NBUCK-1:0] fb_over_hi_i,
    input wire logic [psq_pkg::NBUCK-1:0] fb_below_lo_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic [psq_pkg::NRAIL-1:0] rail_en_o,
    output logic [psq_pkg::NRAIL-1:0] discharge_o,
    output logic [psq_pkg::NBUCK-1:0] switch_off_o,
    output logic reset_out_o,
    output logic host_access_o
);
    import psq_pkg::*;

    typedef struct packed {
        psq_state_t state;
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic key_prev;
        logic grp_prev;
        psq_cfg_t cfg;
        logic [NRAIL-1:0] rail_en;
        logic [NRAIL-1:0] dis_out;
        logic [NBUCK-1:0] ov;
        logic [NRAIL-1:0] seq_mask;
        logic reset_out;
        logic therm_latch;
        logic csum_err;
        logic cfg_mode;
        logic burn_go;
        logic unlocked;
        logic [31:0] burn_cnt;
        logic [7:0] rdata;
    } psq_regs_t;

    psq_regs_t r_ff;
    psq_regs_t nxt_r;

    // nonvolatile store: kept out of reset, survives srst like real fuses
    logic [7:0] nvm_store [NCFG+1];
    psq_cfg_t store_cfg;

    logic key, grp, bias, therm, grp_act, grp_rise, grp_fall;
    logic key_on, key_off, key_fall, grp_func, tick, state_chg, tmr_run;
    logic [NBUCK-1:0] fbh, fbl;
    logic [3:0] slot;
    logic [1:0] tmr_sel;
    logic [NRAIL-1:0] gmask;

    // highest slot used by the rails in a mask; high nibble when dn is set
    function automatic logic [3:0] max_slot(input psq_cfg_t c, input logic [NRAIL-1:0] m,
                                            input logic dn);
        logic [3:0] mx;
        logic [3:0] s;
        mx = 4'h0;
        for (int i = 0; i < NRAIL; i++) begin
            s = dn ? c[i][7:4] : c[i][3:0];
            if (m[i] && s > mx) begin
                mx = s;
            end
        end
        return mx;
    endfunction

    // register read mux; password is write only
    function automatic logic [7:0] rd_mux(input psq_regs_t r, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a < NCFG[7:0]) begin
            d = r.cfg[a[3:0]];
        end else if (a == REG_STATUS) begin
            d[3:0] = r.state;
            d[STAT_CSUM_BIT] = r.csum_err;
            d[STAT_THERM_BIT] = r.therm_latch;
        end else if (a == REG_MODE) begin
            d[MODE_CFG_BIT] = r.cfg_mode;
            d[MODE_BURN_BIT] = r.burn_go;
        end
        return d;
    endfunction

    // ==========================================================
    // synchronised pins and derived factors
    assign key = r_ff.s2[0];
    assign grp = r_ff.s2[1];
    assign bias = r_ff.s2[2];
    assign therm = r_ff.s2[3];
    assign fbh = r_ff.s2[4 +: NBUCK];
    assign fbl = r_ff.s2[4+NBUCK +: NBUCK];
    assign grp_func = r_ff.cfg[REG_CTRL[3:0]][CTRL_GRP_FUNC_BIT];
    assign gmask = r_ff.cfg[REG_GRP_MASK[3:0]];
    assign grp_act = r_ff.cfg[REG_CTRL[3:0]][CTRL_GRP_POL_BIT] ? grp : ~grp;
    assign grp_rise = grp_func && grp_act && !r_ff.grp_prev;
    assign grp_fall = grp_func && !grp_act && r_ff.grp_prev;
    assign key_fall = r_ff.key_prev && !key;
    assign key_on = r_ff.cfg[REG_CTRL[3:0]][CTRL_KEY_EDGE_BIT] ? key_fall : key;
    assign key_off = r_ff.cfg[REG_CTRL[3:0]][CTRL_KEY_EDGE_BIT] ? key_fall : ~key;

    // timer runs in the timed states and restarts at every state change
    assign tmr_run = (r_ff.state == ST_UP_SEQ) || (r_ff.state == ST_DN_SEQ) ||
                     (r_ff.state == ST_RST_WAIT);
    assign tmr_sel = (r_ff.state == ST_DN_SEQ) ?
                     r_ff.cfg[REG_CTRL[3:0]][CTRL_DN_SEL_LSB +: 2] :
                     r_ff.cfg[REG_CTRL[3:0]][CTRL_UP_SEL_LSB +: 2];
    assign state_chg = (nxt_r.state != r_ff.state);

    psq_slot_timer #(
        .CYC0(SLOT_CYC0),
        .CYC1(SLOT_CYC1),
        .CYC2(SLOT_CYC2),
        .CYC3(SLOT_CYC3)
    ) u_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .clr_i(state_chg),
        .run_i(tmr_run),
        .sel_i(tmr_sel),
        .slot_o(slot),
        .tick_o(tick)
    );

    // store image as a config word
    always_comb begin
        for (int i = 0; i < NCFG; i++) begin
            store_cfg[i] = nvm_store[i];
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = {fb_below_lo_i, fb_over_hi_i, thermal_sd_i, bias_supply_ok_i,
                    rail_group_enable_pin_i, power_key_pin_i};
        nxt_r.s2 = r_ff.s1;
        nxt_r.key_prev = key;
        nxt_r.grp_prev = grp_act;

        // host writes; refused before start-up completes and while burning
        if (wr_en_i && host_access_o) begin
            if (wr_addr_i < NCFG[7:0]) begin
                nxt_r.cfg[wr_addr_i[3:0]] = wr_data_i;
            end else if (wr_addr_i == REG_PASSWORD) begin
                nxt_r.unlocked = (wr_data_i == PROG_PASSWORD);
            end else if (wr_addr_i == REG_MODE) begin
                nxt_r.cfg_mode = wr_data_i[MODE_CFG_BIT] && r_ff.unlocked;
                if (r_ff.state == ST_NVM_CFG) begin
                    nxt_r.burn_go = wr_data_i[MODE_BURN_BIT] && wr_data_i[MODE_CFG_BIT];
                end
            end
        end

        case (r_ff.state)
            ST_NO_SUPPLY: begin
                if (bias) begin
                    nxt_r.state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (psq_csum(store_cfg) == nvm_store[NCFG]) begin
                    nxt_r.cfg = store_cfg;
                    nxt_r.csum_err = 1'b0;
                end else begin
                    nxt_r.cfg = CFG_DEFAULT;
                    nxt_r.csum_err = 1'b1;
                end
                nxt_r.state = ST_SHUTDOWN;
            end
            ST_SHUTDOWN: begin
                // key looked at only here and in the on state
                if (r_ff.cfg_mode) begin
                    nxt_r.state = ST_NVM_CFG;
                end else if (r_ff.therm_latch) begin
                    if (!therm) begin
                        nxt_r.therm_latch = 1'b0;
                        nxt_r.seq_mask = '1;
                        nxt_r.state = ST_UP_SEQ;
                    end
                end else if (key_on) begin
                    nxt_r.seq_mask = '1;
                    nxt_r.state = ST_UP_SEQ;
                end else if (grp_rise) begin
                    nxt_r.seq_mask = gmask;
                    nxt_r.state = ST_UP_SEQ;
                end
            end
            ST_UP_SEQ: begin
                for (int i = 0; i < NRAIL; i++) begin
                    if (r_ff.seq_mask[i] && r_ff.cfg[i][3:0] == slot) begin
                        nxt_r.rail_en[i] = 1'b1;
                    end
                end
                if (tick && slot == max_slot(r_ff.cfg, r_ff.seq_mask, 1'b0)) begin
                    nxt_r.state = ST_RST_WAIT;
                end
            end
            ST_RST_WAIT: begin
                // delay is counted in up-timing slot periods, field+1 of them
                if (tick && slot == {2'b00, r_ff.cfg[REG_RST_DLY[3:0]][1:0]}) begin
                    nxt_r.reset_out = 1'b1;
                    nxt_r.state = ST_ON;
                end
            end
            ST_ON: begin
                if (r_ff.cfg_mode || key_off) begin
                    nxt_r.seq_mask = '1;
                    nxt_r.reset_out = 1'b0;
                    nxt_r.state = ST_DN_SEQ;
                end else if (grp_fall) begin
                    nxt_r.seq_mask = gmask;
                    nxt_r.reset_out = 1'b0;
                    nxt_r.state = ST_DN_SEQ;
                end else if (grp_rise && (gmask & ~r_ff.rail_en) != '0) begin
                    nxt_r.seq_mask = gmask;
                    nxt_r.state = ST_UP_SEQ;
                end
            end
            ST_DN_SEQ: begin
                for (int i = 0; i < NRAIL; i++) begin
                    if (r_ff.seq_mask[i] && r_ff.cfg[i][7:4] == slot) begin
                        nxt_r.rail_en[i] = 1'b0;
                    end
                end
                if (tick && slot == max_slot(r_ff.cfg, r_ff.seq_mask, 1'b1)) begin
                    if (r_ff.seq_mask != '1) begin
                        nxt_r.state = ST_RST_WAIT;
                    end else if (r_ff.cfg_mode) begin
                        nxt_r.state = ST_NVM_CFG;
                    end else begin
                        nxt_r.state = ST_SHUTDOWN;
                    end
                end
            end
            ST_NVM_CFG: begin
                nxt_r.rail_en = '0;
                nxt_r.burn_cnt = 32'h0;
                if (r_ff.burn_go) begin
                    nxt_r.state = ST_NVM_BURN;
                end else if (!r_ff.cfg_mode) begin
                    nxt_r.state = ST_SHUTDOWN;
                end
            end
            ST_NVM_BURN: begin
                nxt_r.burn_cnt = r_ff.burn_cnt + 32'h1;
                if (r_ff.burn_cnt == BURN_CYC - 32'h1) begin
                    nxt_r.burn_go = 1'b0;
                    nxt_r.cfg_mode = 1'b0;
                    nxt_r.unlocked = 1'b0;
                    nxt_r.state = ST_LOAD;
                end
            end
            default: begin
                nxt_r.state = ST_NO_SUPPLY;
            end
        endcase

        // shutdown events beat everything and drop all rails together
        if (!bias) begin
            nxt_r.state = ST_NO_SUPPLY;
            nxt_r.rail_en = '0;
            nxt_r.reset_out = 1'b0;
            nxt_r.therm_latch = 1'b0;
            nxt_r.cfg_mode = 1'b0;
            nxt_r.burn_go = 1'b0;
            nxt_r.unlocked = 1'b0;
        end else if (therm && r_ff.state != ST_NO_SUPPLY && r_ff.state != ST_LOAD) begin
            nxt_r.state = ST_SHUTDOWN;
            nxt_r.rail_en = '0;
            nxt_r.reset_out = 1'b0;
            nxt_r.therm_latch = 1'b1;
            nxt_r.cfg_mode = 1'b0;
            nxt_r.burn_go = 1'b0;
        end

        // over-voltage latch: set wins over release
        nxt_r.ov = (r_ff.ov | fbh) & ~(fbl & ~fbh);
        // discharge follows the next rail state so it is registered with it
        nxt_r.dis_out = ~nxt_r.rail_en & nxt_r.cfg[REG_DIS_MASK[3:0]];
        nxt_r.dis_out[NBUCK-1:0] = nxt_r.dis_out[NBUCK-1:0] | nxt_r.ov;
        nxt_r.rdata = rd_mux(r_ff, rd_addr_i);
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_ff <= '0;
        end else if (ce_i) begin
            r_ff <= nxt_r;
        end
    end

    // ==========================================================
    // store: erased at power-up so the first load falls back to defaults
    initial begin
        for (int i = 0; i <= NCFG; i++) begin
            nvm_store[i] = 8'h00;
        end
    end

    // burn writes settings and checksum in the cycle the burn starts
    always_ff @(posedge clk_i) begin
        if (ce_i && r_ff.state == ST_NVM_CFG && r_ff.burn_go && !srst_i) begin
            for (int i = 0; i < NCFG; i++) begin
                nvm_store[i] <= r_ff.cfg[i];
            end
            nvm_store[NCFG] <= psq_csum(r_ff.cfg);
        end
    end

    // ==========================================================
    // outputs
    assign host_access_o = (r_ff.state == ST_ON) || (r_ff.state == ST_NVM_CFG);
    assign rd_data_o = r_ff.rdata;
    assign rail_en_o = r_ff.rail_en;
    assign discharge_o = r_ff.dis_out;
    assign switch_off_o = r_ff.ov;
    assign reset_out_o = r_ff.reset_out;

endmodule
`default_nettype wire

// ### verif/psq_host_model.sv
// host-side partner model: key pin and register port of the sequencer
`timescale 1ns/10ps
`default_nettype none
module psq_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output logic power_key_pin_o,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] rd_addr_o
);
    // ======
    // idle levels, all lines driven from time zero
    initial begin
        power_key_pin_o = 1'b0;
        wr_en_o = 1'b0;
        wr_addr_o = 8'h00;
        wr_data_o = 8'h00;
        rd_addr_o = 8'h00;
    end
    // one-cycle strobe; released lines are scrambled so stale data never passes
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        wr_en_o = 1'b1;
        wr_addr_o = a;
        wr_data_o = d;
        @(posedge clk_i) #1;
        wr_en_o = 1'b0;
        wr_addr_o = ~a;
        wr_data_o = ~d;
    endtask
    // read data is registered, so it is taken one edge after the address
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        rd_addr_o = a;
        @(posedge clk_i) #1;
        d = rd_data_i;
    endtask
    task automatic key(input logic v);
        @(posedge clk_i) #1;
        power_key_pin_o = v;
    endtask
endmodule
`default_nettype wire

// ### verif/psq_power_state_sequencer_properties.sv
// concurrent checks on the sequencer's ports
`timescale 1ns/10ps
`default_nettype none
module psq_checker
    import psq_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic bias_supply_ok_i,
    input wire logic thermal_sd_i,
    input wire logic [psq_pkg::NBUCK-1:0] fb_over_hi_i,
    input wire logic [psq_pkg::NBUCK-1:0] fb_below_lo_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [psq_pkg::NRAIL-1:0] rail_en_o,
    input wire logic [psq_pkg::NRAIL-1:0] discharge_o,
    input wire logic [psq_pkg::NBUCK-1:0] switch_off_o,
    input wire logic reset_out_o,
    input wire logic host_access_o
);
    // ======
    // pins pass two sync stages, so four cycles cover sync plus action
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chk_bias_off: assert property (
        (!bias_supply_ok_i && ce_i) [*4] |=> rail_en_o == '0 && !reset_out_o)
        else $error("rails on after bias loss");
    chk_therm_off: assert property (
        (thermal_sd_i && ce_i) [*4] |=> rail_en_o == '0) else $error("rails on in thermal trip");
    chk_reset_first: assert property (
        ($past(rail_en_o) & ~rail_en_o) != '0 |-> !reset_out_o)
        else $error("rail dropped while reset released");
    chk_reset_access: assert property (
        reset_out_o |-> host_access_o) else $error("reset released outside on state");
    chk_ov_set: assert property (
        fb_over_hi_i[0] [*3] |=> switch_off_o[0] && discharge_o[0])
        else $error("over-voltage not latched");
    chk_ov_clear: assert property (
        (fb_below_lo_i[0] && !fb_over_hi_i[0]) [*3] |=> !switch_off_o[0])
        else $error("over-voltage latch not released");
    chk_discharge_off: assert property (
        switch_off_o == '0 && $past(switch_off_o) == '0
        |-> (discharge_o & rail_en_o & $past(rail_en_o)) == '0)
        else $error("discharge on an enabled rail");
    chk_pwd_read: assert property (
        ce_i && rd_addr_i == REG_PASSWORD |=> rd_data_o == 8'h00)
        else $error("password register readable");
endmodule
bind psq_power_state_sequencer psq_checker i_psq_checker (.clk_i, .srst_i, .ce_i,
    .bias_supply_ok_i, .thermal_sd_i, .fb_over_hi_i, .fb_below_lo_i, .rd_addr_i, .rd_data_o,
    .rail_en_o, .discharge_o, .switch_off_o, .reset_out_o, .host_access_o);
`default_nettype wire

// ### verif/psq_power_state_sequencer_tb.sv
// self-checking bench for the power state sequencer
`timescale 1ns/10ps
`default_nettype none
module psq_power_state_sequencer_tb;
    import psq_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} psq_row_t;
    // ======
    // write then read back: plain, read-only, write-only and unmapped places
    localparam psq_row_t ROWS [6] = '{'{8'h09, 8'h0C, 8'h0C}, '{8'h0A, 8'h7F, 8'h7F},
        '{8'h08, 8'h10, 8'h10}, '{8'h26, 8'h5A, 8'h00}, '{8'h0C, 8'h00, 8'h15},
        '{8'h40, 8'h33, 8'h00}};
    logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, bias_supply_ok_i = 1'b0, thermal_sd_i = 1'b0;
    logic rail_group_enable_pin_i = 1'b0, power_key_pin_i, wr_en_i, reset_out_o, host_access_o;
    logic [3:0] fb_over_hi_i = 4'h0, fb_below_lo_i = 4'h0, switch_off_o;
    logic [7:0] wr_addr_i, wr_data_i, rd_addr_i, rd_data_o, rail_en_o, discharge_o, v;
    int fails = 0, checks = 0;
    // short slots and burn keep the run brief
    psq_power_state_sequencer #(.SLOT_CYC0(4), .SLOT_CYC1(4), .SLOT_CYC2(4), .SLOT_CYC3(4),
        .BURN_CYC(8), .PROG_PASSWORD(8'h5A)) i_psq_power_state_sequencer (.clk_i, .srst_i,
        .ce_i, .bias_supply_ok_i, .thermal_sd_i, .power_key_pin_i, .rail_group_enable_pin_i,
        .fb_over_hi_i, .fb_below_lo_i, .wr_en_i, .wr_addr_i, .wr_data_i, .rd_addr_i,
        .rd_data_o, .rail_en_o, .discharge_o, .switch_off_o, .reset_out_o, .host_access_o);
    psq_host_model i_psq_host_model (.clk_i, .rd_data_i(rd_data_o),
        .power_key_pin_o(power_key_pin_i), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
        .wr_data_o(wr_data_i), .rd_addr_o(rd_addr_i));
    always #2.5 clk_i = ~clk_i;
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        i_psq_host_model.read(a, v);
        chk(n, e, v);
    endtask
    // bounded poll of the state field; running out ends the run
    task automatic wait_st(input logic [3:0] s);
        int i;
        for (i = 0; i < 300; i++) begin
            i_psq_host_model.read(REG_STATUS, v);
            if (v[3:0] === s) break;
        end
        chk("state", {4'h0, s}, {4'h0, v[3:0]});
        if (i == 300) final_report();
    endtask
    task automatic key_pulse();
        i_psq_host_model.key(1'b1);
        repeat (6) @(posedge clk_i);
        i_psq_host_model.key(1'b0);
    endtask
    // ======
    // main sequence: power-up, table, then the awkward cases
    initial begin
        int i;
        repeat (8) @(posedge clk_i);
        #1 srst_i = 1'b0;
        chk("rails_rst", 8'h00, rail_en_o);
        bias_supply_ok_i = 1'b1;
        wait_st(4'h2);
        for (i = 0; i < NCFG; i++) rd(i[7:0], CFG_DEFAULT[i], "default");
        rd(REG_STATUS, 8'h12, "status");
        i_psq_host_model.key(1'b1);
        for (i = 0; i < 100 && rail_en_o == '0; i++) @(posedge clk_i) #1;
        chk("slot0", 8'h01, rail_en_o);
        repeat (4) @(posedge clk_i);
        #1 chk("slot1", 8'h03, rail_en_o);
        wait_st(4'h5);
        chk("rails_on", 8'hFF, rail_en_o);
        foreach (ROWS[r]) begin
            i_psq_host_model.write(ROWS[r].a, ROWS[r].d);
            rd(ROWS[r].a, ROWS[r].e, "reg");
        end
        i_psq_host_model.key(1'b0);
        for (i = 0; i < 100 && reset_out_o; i++) @(posedge clk_i) #1;
        chk("rails_at_reset_low", 8'hFF, rail_en_o);
        wait_st(4'h2);
        chk("rails_down", 8'h00, rail_en_o);
        key_pulse();
        wait_st(4'h5);
        thermal_sd_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk("rails_therm", 8'h00, rail_en_o);
        thermal_sd_i = 1'b0;
        wait_st(4'h5);
        fb_over_hi_i = 4'h1;
        repeat (5) @(posedge clk_i);
        #1 chk("sw_off", 8'h01, {4'h0, switch_off_o});
        fb_over_hi_i = 4'h0;
        fb_below_lo_i = 4'hF;
        repeat (5) @(posedge clk_i);
        #1 chk("sw_on", 8'h00, {4'h0, switch_off_o});
        // group pin parked at its new active level before the function is on; the rise seen then finds the group rails already on
        rail_group_enable_pin_i = 1'b1;
        repeat (4) @(posedge clk_i);
        i_psq_host_model.write(REG_CTRL, 8'h70);
        rail_group_enable_pin_i = 1'b0;
        for (i = 0; i < 100 && reset_out_o; i++) @(posedge clk_i) #1;
        chk("grp_reset_low", 8'h00, {7'h0, reset_out_o});
        wait_st(4'h5);
        chk("rails_grp", 8'hF3, rail_en_o);
        i_psq_host_model.write(REG_PASSWORD, 8'h5A);
        i_psq_host_model.write(REG_MODE, 8'h01);
        wait_st(4'h7);
        chk("rails_cfg", 8'h00, rail_en_o);
        i_psq_host_model.write(REG_MODE, 8'h03);
        wait_st(4'h2);
        key_pulse();
        wait_st(4'h5);
        rd(REG_MODE, 8'h00, "mode");
        rd(REG_GRP_MASK, 8'h0C, "mask");
        i_psq_host_model.read(REG_STATUS, v);
        chk("csum_err", 8'h00, {7'h0, v[STAT_CSUM_BIT]});
        // clock enable low freezes the synchronisers, so the bias loss is not seen yet
        ce_i = 1'b0;
        bias_supply_ok_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1 chk("rails_frozen", 8'hFF, rail_en_o);
        ce_i = 1'b1;
        repeat (5) @(posedge clk_i);
        #1 chk("rails_bias", 8'h00, rail_en_o);
        wait_st(4'h0);
        final_report();
    end
endmodule
`default_nettype wire
